// ==== bench/mra_bus_model.sv ====
// Bus-side model that completes data accesses and accepts fetches.
`timescale 1ns/1ps
module mra_bus_model (
  // Clock, reset and slow-completion control.
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 hold_done,
  // Data bus.
  input  wire logic                 dbus_valid,
  input  mra_pkg::mra_data_req_type dbus_req,
  input  mra_pkg::mra_attr_type     dbus_attr,
  output logic                      dbus_ready,
  output logic                      dbus_done,
  output mra_pkg::mra_tag_type      dbus_done_tag,
  output logic [31:0]               dbus_rdata,
  // Instruction bus.
  input  wire logic                 ibus_valid,
  input  wire logic [31:0]          ibus_addr,
  output logic                      ibus_ready
);
  mra_pkg::mra_tag_type tag_q[$];
  logic [31:0]          addr_q[$];

  // Completions return in acceptance order, one a cycle, and stop while
  // hold_done is high so that the bench can keep accesses in flight.
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      tag_q.delete();
      addr_q.delete();
      dbus_done     <= 1'b0;
      dbus_done_tag <= '0;
      dbus_rdata    <= 32'h0;
    end
    else
    begin
      if (!hold_done && tag_q.size() > 0)
      begin
        dbus_done     <= 1'b1;
        dbus_done_tag <= tag_q.pop_front();
        dbus_rdata    <= addr_q.pop_front() ^ 32'h5A5A5A5A;
      end
      else
      begin
        dbus_done  <= 1'b0;
        // Read data is not held once its completion has gone.
        dbus_rdata <= ~dbus_rdata;
      end
      if (dbus_valid && dbus_ready)
      begin
        tag_q.push_back('{attr: dbus_attr, write: dbus_req.write});
        addr_q.push_back(dbus_req.addr);
      end
    end
  end

  // Both buses accept at once; slowness is shown by late completions.
  assign dbus_ready = 1'b1;
  assign ibus_ready = 1'b1;
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the region attribute and ordering unit.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("MISMATCH at %0t got %0h exp %0h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  logic                      clk = 1'b0;
  logic                      rst_b = 1'b0;
  logic                      core_dvalid = 1'b0;
  mra_pkg::mra_data_req_type core_dreq = '0;
  logic                      core_fvalid = 1'b0;
  logic [31:0]               core_faddr = 32'h0;
  logic                      b_mem = 1'b0;
  logic                      b_sync = 1'b0;
  logic                      b_inst = 1'b0;
  logic                      hold = 1'b0;
  logic                      core_dready, core_wack, core_rvalid;
  logic                      core_fready, core_fault, bar_busy, exec_hold;
  logic                      bar_done, sync_commit, fetch_flush;
  logic                      dbus_valid, dbus_ready, dbus_done;
  logic                      ibus_valid, ibus_ready;
  logic [31:0]               core_rdata, core_fault_addr, dbus_rdata;
  logic [31:0]               ibus_addr;
  mra_pkg::mra_data_req_type dbus_req;
  mra_pkg::mra_attr_type     dbus_attr;
  mra_pkg::mra_tag_type      dbus_done_tag;
  int                        num_errors = 0;
  int                        n_compared = 0;

  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;

  mra_order_unit #(.CNT_W(4)) mra_order_unit_inst (
    .clk(clk), .rst_b(rst_b), .core_dvalid(core_dvalid),
    .core_dreq(core_dreq), .core_dready(core_dready),
    .core_wack(core_wack), .core_rvalid(core_rvalid),
    .core_rdata(core_rdata), .core_fvalid(core_fvalid),
    .core_faddr(core_faddr), .core_fready(core_fready),
    .core_fault(core_fault), .core_fault_addr(core_fault_addr),
    .data_memory_barrier(b_mem), .data_sync_barrier(b_sync),
    .instruction_sync_barrier(b_inst), .bar_busy(bar_busy),
    .exec_hold(exec_hold), .bar_done(bar_done),
    .sync_commit(sync_commit), .fetch_flush(fetch_flush),
    .dbus_valid(dbus_valid), .dbus_req(dbus_req), .dbus_attr(dbus_attr),
    .dbus_ready(dbus_ready), .dbus_done(dbus_done),
    .dbus_done_tag(dbus_done_tag), .dbus_rdata(dbus_rdata),
    .ibus_valid(ibus_valid), .ibus_addr(ibus_addr),
    .ibus_ready(ibus_ready));

  mra_bus_model mra_bus_model_inst (
    .clk(clk), .rst_b(rst_b), .hold_done(hold),
    .dbus_valid(dbus_valid), .dbus_req(dbus_req), .dbus_attr(dbus_attr),
    .dbus_ready(dbus_ready), .dbus_done(dbus_done),
    .dbus_done_tag(dbus_done_tag), .dbus_rdata(dbus_rdata),
    .ibus_valid(ibus_valid), .ibus_addr(ibus_addr),
    .ibus_ready(ibus_ready));

  task automatic close_out();
    $display("Compared %0d values, %0d errors", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Waits for rvalid (0), wack (1) or bar_done (2); a spent bound ends the run.
  task automatic wait_hi(input int sel, input int lim);
    int   k;
    logic s;
    k = 0;
    s = 1'b0;
    while (s !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      #1;
      s = (sel == 0) ? core_rvalid : (sel == 1) ? core_wack : bar_done;
      k++;
    end
    if (s !== 1'b1)
    begin
      `CHK(s, 1'b1)
      close_out();
    end
  endtask

  // Holds a data request until taken; returns 1 ns after the taking edge.
  task automatic send(input logic [31:0] a, input logic w, input logic sh,
                      input int lim);
    int k;
    k = 0;
    @(posedge clk);
    core_dvalid <= 1'b1;
    core_dreq   <= '{addr: a, wdata: ~a, write: w, shareable: sh};
    #1;
    while (core_dready !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (core_dready !== 1'b1)
    begin
      `CHK(core_dready, 1'b1)
      close_out();
    end
    @(posedge clk);
    core_dvalid <= 1'b0;
    #1;
  endtask

  // Offers a write for one cycle and reports whether it would be taken.
  task automatic probe(input logic [31:0] a, input logic sh, output logic r);
    @(posedge clk);
    core_dvalid <= 1'b1;
    core_dreq   <= '{addr: a, wdata: a, write: 1'b1, shareable: sh};
    #1;
    r = core_dready;
    @(posedge clk);
    core_dvalid <= 1'b0;
  endtask

  // Region boundaries: read and fetch the same address in one cycle.
  task automatic t_decode();
    logic [31:0] ad [13] = '{32'h00000000, 32'h1FFFFFFF, 32'h20000000,
      32'h40000000, 32'h5FFFFFFF, 32'h60000000, 32'h9FFFFFFF, 32'hA0000000,
      32'hDFFFFFFF, 32'hE0000000, 32'hE00FFFFF, 32'hE0100000, 32'hFFFFFFFF};
    mra_pkg::mra_mem_kind_type kd [13] = '{mra_pkg::MT_NORMAL,
      mra_pkg::MT_NORMAL, mra_pkg::MT_NORMAL, mra_pkg::MT_DEVICE,
      mra_pkg::MT_DEVICE, mra_pkg::MT_NORMAL, mra_pkg::MT_NORMAL,
      mra_pkg::MT_DEVICE, mra_pkg::MT_DEVICE, mra_pkg::MT_STRONG,
      mra_pkg::MT_STRONG, mra_pkg::MT_DEVICE, mra_pkg::MT_DEVICE};
    logic no_exec;
    for (int i = 0; i < 13; i++)
    begin
      no_exec = (kd[i] != mra_pkg::MT_NORMAL);
      @(posedge clk);
      core_dvalid <= 1'b1;
      core_dreq   <= '{addr: ad[i], wdata: 32'h0, write: 1'b0,
                       shareable: 1'b0};
      core_fvalid <= 1'b1;
      core_faddr  <= ad[i];
      #1;
      `CHK({core_dready, core_fready}, 2'h3)
      @(posedge clk);
      core_dvalid <= 1'b0;
      core_fvalid <= 1'b0;
      #1;
      `CHK(dbus_valid, 1'b1)
      `CHK(dbus_req.addr, ad[i])
      `CHK(dbus_attr.kind, kd[i])
      `CHK(dbus_attr.execute_never_attr, no_exec)
      `CHK(core_fault, no_exec)
      `CHK(ibus_valid, ~no_exec)
      if (no_exec)
        `CHK(core_fault_addr, ad[i])
      else
        `CHK(ibus_addr, ad[i])
      wait_hi(0, 20);
      `CHK(core_rdata, ad[i] ^ 32'h5A5A5A5A)
    end
  endtask

  // Completions held back so that ordering decisions can be seen.
  task automatic t_order();
    logic r;
    @(posedge clk);
    hold <= 1'b1;
    send(32'h40000000, 1'b1, 1'b0, 0);
    `CHK(core_wack, 1'b1)
    `CHK(dbus_req.wdata, 32'hBFFFFFFF)
    probe(32'h40000010, 1'b0, r);
    `CHK(r, 1'b0)
    send(32'h40000020, 1'b1, 1'b1, 0);
    `CHK(dbus_attr.shareable, 1'b1)
    send(32'h20000000, 1'b1, 1'b0, 0);
    probe(32'hE0000000, 1'b0, r);
    `CHK(r, 1'b0)
    @(posedge clk);
    hold <= 1'b0;
    send(32'hE0000004, 1'b1, 1'b0, 20);
    `CHK(core_wack, 1'b0)
    wait_hi(1, 20);
    @(posedge clk);
    hold <= 1'b1;
    send(32'hE0000008, 1'b1, 1'b0, 20);
    probe(32'h40000000, 1'b1, r);
    `CHK(r, 1'b0)
    probe(32'h20000000, 1'b0, r);
    `CHK(r, 1'b0)
    @(posedge clk);
    hold <= 1'b0;
    wait_hi(1, 20);
  endtask

  // Each barrier kind, drained at once and with an access in flight.
  task automatic t_barrier();
    for (int k = 0; k < 3; k++)
      for (int d = 0; d < 2; d++)
      begin
        if (d == 1)
        begin
          @(posedge clk);
          hold <= 1'b1;
          send(32'h40000000, 1'b1, 1'b0, 20);
        end
        @(posedge clk);
        b_mem  <= (k == 0);
        b_sync <= (k == 1);
        b_inst <= (k == 2);
        @(posedge clk);
        b_mem  <= 1'b0;
        b_sync <= 1'b0;
        b_inst <= 1'b0;
        #1;
        `CHK(bar_busy, 1'b1)
        `CHK(core_dready, 1'b0)
        `CHK(exec_hold, k == 1)
        `CHK(core_fready, k != 2)
        if (d == 1)
        begin
          @(posedge clk);
          hold <= 1'b0;
        end
        wait_hi(2, (d == 0) ? 1 : 20);
        `CHK(sync_commit, k == 1)
        `CHK(fetch_flush, k == 2)
        `CHK(bar_busy, 1'b0)
      end
  endtask

  // Reset, then each scenario in turn.
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    `CHK({core_dready, core_fready, bar_busy}, 3'h6)
    t_decode();
    t_order();
    t_barrier();
    close_out();
  end
endmodule

// ==== core/mra_order_unit.sv ====
// Region attribute decode, access ordering and barrier logic for one core.
// Contract
// - Normal accesses need no ordering; they only wait behind strong ones.
// - Device accesses stay in order with same-shareability device and with strong accesses.
// - Strongly-ordered accesses stay in order with every other access.
// - Device writes are posted; strong writes ack only on completion.
// - Fetches from execute-never regions are blocked and raise a fault.
// - Device/strong pairs of matching shareability are observed in order.
// - No ordering between normal and device, or across device shareability.
// - Code, internal RAM and external RAM decode normal, executable.
// - Peripheral, external device and vendor regions are device, no-exec.
// - Private peripheral bus window decodes strongly-ordered, no-exec.
// - Fetch and data paths are separate and may both move each cycle.
// - Data memory barrier drains all accesses before any later one starts.
// - Data sync barrier drains all accesses before later instructions run.
// - Instruction sync barrier drains, flushes and refetches younger code.
// - Vector write, barrier, then exception fetch sees the new vector.
// - Code write then instruction sync barrier runs the modified code.
// - Map switch then data sync barrier runs under the new map.
// - Exception priority change takes effect by data sync barrier end.
// - Barrier after semaphore accesses shows them to others in order.
`timescale 1ns/1ps
module mra_order_unit #(
  parameter int CNT_W = 4
) (
  // Clock and synchronous reset.
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // Load/store unit request.
  input  wire logic                     core_dvalid,
  input  mra_pkg::mra_data_req_type     core_dreq,
  output logic                          core_dready,
  // Load/store unit answers.
  output logic                          core_wack,
  output logic                          core_rvalid,
  output logic [31:0]                   core_rdata,
  // Fetch unit request and fault.
  input  wire logic                     core_fvalid,
  input  wire logic [31:0]              core_faddr,
  output logic                          core_fready,
  output logic                          core_fault,
  output logic [31:0]                   core_fault_addr,
  // Barrier requests and their effects.
  input  wire logic                     data_memory_barrier,
  input  wire logic                     data_sync_barrier,
  input  wire logic                     instruction_sync_barrier,
  output logic                          bar_busy,
  output logic                          exec_hold,
  output logic                          bar_done,
  output logic                          sync_commit,
  output logic                          fetch_flush,
  // Data bus master side.
  output logic                          dbus_valid,
  output mra_pkg::mra_data_req_type     dbus_req,
  output mra_pkg::mra_attr_type         dbus_attr,
  input  wire logic                     dbus_ready,
  input  wire logic                     dbus_done,
  input  mra_pkg::mra_tag_type          dbus_done_tag,
  input  wire logic [31:0]              dbus_rdata,
  // Instruction bus master side.
  output logic                          ibus_valid,
  output logic [31:0]                   ibus_addr,
  input  wire logic                     ibus_ready
);

  // Whole state of the unit in one record.
  typedef struct packed {
    mra_pkg::mra_bar_state_type bar;
    logic [3:0][CNT_W-1:0]      cnt;
    logic                       dvalid;
    mra_pkg::mra_data_req_type  dreq;
    mra_pkg::mra_attr_type      dattr;
    logic                       fvalid;
    logic [31:0]                faddr;
    logic                       fault;
    logic [31:0]                fault_addr;
    logic                       wack;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic                       done;
    logic                       commit;
    logic                       flush;
  } mra_state_type;

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  mra_state_type         st;
  mra_state_type         next_st;
  mra_pkg::mra_attr_type d_attr;
  mra_pkg::mra_attr_type f_attr;
  logic [1:0]            d_cls;
  logic [1:0]            done_cls;
  logic [CNT_W+1:0]      total;
  logic                  drained;
  logic                  d_free;
  logic                  f_free;
  logic                  d_take;
  logic                  f_take;

  // Map attributes to the counter that tracks their ordering class.
  function automatic logic [1:0] cls_of(input mra_pkg::mra_attr_type a);
    logic [1:0] c;
    c = mra_pkg::CLS_NORMAL;
    if (a.kind == mra_pkg::MT_STRONG)
      c = mra_pkg::CLS_STRONG;
    else if (a.kind == mra_pkg::MT_DEVICE)
      c = a.shareable ? mra_pkg::CLS_DEV_SH : mra_pkg::CLS_DEV_NS;
    return c;
  endfunction

  // Decide whether an access of one class may start now.
  function automatic logic may_issue(input logic [1:0] c,
                                     input logic [3:0][CNT_W-1:0] n,
                                     input logic [CNT_W+1:0] tot);
    logic ok;
    ok = 1'b0;
    case (c)
      mra_pkg::CLS_STRONG: ok = (tot == '0);
      mra_pkg::CLS_DEV_NS: ok = (n[mra_pkg::CLS_DEV_NS] == '0) &&
                                (n[mra_pkg::CLS_STRONG] == '0);
      mra_pkg::CLS_DEV_SH: ok = (n[mra_pkg::CLS_DEV_SH] == '0) &&
                                (n[mra_pkg::CLS_STRONG] == '0);
      default:             ok = (n[mra_pkg::CLS_STRONG] == '0);
    endcase
    return ok && (n[c] != CNT_MAX);
  endfunction

  // Both paths decode in the request cycle so checks see attributes at once.
  mra_region_decode u_ddec (
    .addr      (core_dreq.addr),
    .shareable (core_dreq.shareable),
    .attr      (d_attr)
  );

  mra_region_decode u_fdec (
    .addr      (core_faddr),
    .shareable (1'b0),
    .attr      (f_attr)
  );

  // Outstanding totals; a drained unit has no data access staged or in flight.
  assign d_cls    = cls_of(d_attr);
  assign done_cls = cls_of(dbus_done_tag.attr);
  assign total    = (CNT_W+2)'(st.cnt[0]) + (CNT_W+2)'(st.cnt[1]) +
                    (CNT_W+2)'(st.cnt[2]) + (CNT_W+2)'(st.cnt[3]);
  assign drained  = (total == '0);

  // Request handshakes; the data path never waits on the fetch path.
  assign d_free      = !st.dvalid || dbus_ready;
  assign f_free      = !st.fvalid || ibus_ready;
  assign core_dready = d_free && (st.bar == mra_pkg::BS_IDLE) &&
                       may_issue(d_cls, st.cnt, total);
  assign core_fready = f_free && (st.bar != mra_pkg::BS_INST_BAR);
  assign d_take      = core_dvalid && core_dready;
  assign f_take      = core_fvalid && core_fready;

  // Next state: staging, counting, answers and the barrier sequencer.
  always_comb
  begin
    next_st        = st;
    next_st.fault  = 1'b0;
    next_st.wack   = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.done   = 1'b0;
    next_st.commit = 1'b0;
    next_st.flush  = 1'b0;
    if (st.dvalid && dbus_ready)
      next_st.dvalid = 1'b0;
    // Count from acceptance so a staged access already blocks younger ones.
    if (d_take)
    begin
      next_st.dvalid = 1'b1;
      next_st.dreq   = core_dreq;
      next_st.dattr  = d_attr;
      next_st.cnt[d_cls] = next_st.cnt[d_cls] + CNT_ONE;
      if (core_dreq.write && d_attr.kind != mra_pkg::MT_STRONG)
        next_st.wack = 1'b1;
    end
    if (dbus_done)
    begin
      next_st.cnt[done_cls] = next_st.cnt[done_cls] - CNT_ONE;
      if (!dbus_done_tag.write)
      begin
        next_st.rvalid = 1'b1;
        next_st.rdata  = dbus_rdata;
      end
      else if (dbus_done_tag.attr.kind == mra_pkg::MT_STRONG)
        next_st.wack = 1'b1;
    end
    // Fetch staging; blocked fetches never reach the instruction bus.
    if (st.fvalid && ibus_ready)
      next_st.fvalid = 1'b0;
    if (f_take)
    begin
      if (f_attr.execute_never_attr)
      begin
        next_st.fault      = 1'b1;
        next_st.fault_addr = core_faddr;
      end
      else
      begin
        next_st.fvalid = 1'b1;
        next_st.faddr  = core_faddr;
      end
    end
    // Barriers are taken one at a time; the sync barrier wins a tie.
    case (st.bar)
      mra_pkg::BS_IDLE:
      begin
        if (data_sync_barrier)
          next_st.bar = mra_pkg::BS_SYNC_BAR;
        else if (instruction_sync_barrier)
          next_st.bar = mra_pkg::BS_INST_BAR;
        else if (data_memory_barrier)
          next_st.bar = mra_pkg::BS_MEM_BAR;
      end
      mra_pkg::BS_MEM_BAR:
      begin
        if (drained)
        begin
          next_st.bar  = mra_pkg::BS_IDLE;
          next_st.done = 1'b1;
        end
      end
      mra_pkg::BS_SYNC_BAR:
      begin
        if (drained)
        begin
          next_st.bar    = mra_pkg::BS_IDLE;
          next_st.done   = 1'b1;
          next_st.commit = 1'b1;
        end
      end
      mra_pkg::BS_INST_BAR:
      begin
        if (drained)
        begin
          next_st.bar   = mra_pkg::BS_IDLE;
          next_st.done  = 1'b1;
          next_st.flush = 1'b1;
        end
      end
      default:
        next_st.bar = mra_pkg::BS_IDLE;
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end

  // Every output except core_dready and core_fready comes from the state record.
  assign core_wack       = st.wack;
  assign core_rvalid     = st.rvalid;
  assign core_rdata      = st.rdata;
  assign core_fault      = st.fault;
  assign core_fault_addr = st.fault_addr;
  assign bar_busy        = (st.bar != mra_pkg::BS_IDLE);
  assign exec_hold       = (st.bar == mra_pkg::BS_SYNC_BAR);
  assign bar_done        = st.done;
  assign sync_commit     = st.commit;
  assign fetch_flush     = st.flush;
  assign dbus_valid      = st.dvalid;
  assign dbus_req        = st.dreq;
  assign dbus_attr       = st.dattr;
  assign ibus_valid      = st.fvalid;
  assign ibus_addr       = st.faddr;

  // Checks on ordering, decode and barrier behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_drain_done;
    drained ##1 (bar_done && !bar_busy);
  endsequence

  sequence s_flush_pulse;
    fetch_flush ##1 !fetch_flush;
  endsequence

  property p_strong_alone;
    d_take && d_attr.kind == mra_pkg::MT_STRONG |-> drained;
  endproperty
  a_strong_alone: assert property (p_strong_alone)
    else $error("Strong access issued with others outstanding.");

  property p_behind_strong;
    st.cnt[mra_pkg::CLS_STRONG] != '0 |-> !d_take;
  endproperty
  a_behind_strong: assert property (p_behind_strong)
    else $error("Access started behind an unfinished strong access.");

  property p_device_order;
    d_take && d_cls == mra_pkg::CLS_DEV_NS |->
      st.cnt[mra_pkg::CLS_DEV_NS] == '0;
  endproperty
  a_device_order: assert property (p_device_order)
    else $error("Device access overtook an older device access.");

  property p_posted_write;
    d_take && core_dreq.write && d_attr.kind == mra_pkg::MT_DEVICE
      |=> core_wack;
  endproperty
  a_posted_write: assert property (p_posted_write)
    else $error("Device write was not acknowledged at acceptance.");

  property p_no_exec_fault;
    f_take && f_attr.execute_never_attr |=>
      core_fault && !ibus_valid && core_fault_addr == $past(core_faddr);
  endproperty
  a_no_exec_fault: assert property (p_no_exec_fault)
    else $error("Execute-never fetch not faulted or was forwarded.");

  property p_priv_bus_decode;
    core_fvalid && core_faddr >= mra_pkg::PRIV_BUS_BASE &&
      core_faddr <= mra_pkg::PRIV_BUS_LAST |->
      f_attr.kind == mra_pkg::MT_STRONG && f_attr.execute_never_attr;
  endproperty
  a_priv_bus_decode: assert property (p_priv_bus_decode)
    else $error("Private bus window decoded wrongly.");

  property p_xram_decode;
    core_fvalid && core_faddr >= mra_pkg::XRAM_BASE &&
      core_faddr < mra_pkg::XDEV_BASE |->
      f_attr.kind == mra_pkg::MT_NORMAL && !f_attr.execute_never_attr;
  endproperty
  a_xram_decode: assert property (p_xram_decode)
    else $error("External RAM decoded wrongly.");

  property p_periph_decode;
    core_dvalid && core_dreq.addr >= mra_pkg::PERIPH_BASE &&
      core_dreq.addr < mra_pkg::XRAM_BASE |->
      d_attr.kind == mra_pkg::MT_DEVICE && d_attr.execute_never_attr;
  endproperty
  a_periph_decode: assert property (p_periph_decode)
    else $error("Peripheral region decoded wrongly.");

  property p_mem_bar_block;
    st.bar == mra_pkg::BS_MEM_BAR |-> !core_dready;
  endproperty
  a_mem_bar_block: assert property (p_mem_bar_block)
    else $error("Data accepted during a memory barrier.");

  property p_sync_bar_end;
    st.bar == mra_pkg::BS_SYNC_BAR && exec_hold |->
      (!drained ##1 exec_hold) or (s_drain_done ##0 sync_commit);
  endproperty
  a_sync_bar_end: assert property (p_sync_bar_end)
    else $error("Sync barrier ended early or without commit.");

  property p_inst_bar_flush;
    st.bar == mra_pkg::BS_INST_BAR && drained |=> s_flush_pulse;
  endproperty
  a_inst_bar_flush: assert property (p_inst_bar_flush)
    else $error("Instruction barrier did not flush once.");

endmodule

// ==== core/mra_pkg.sv ====
// Shared constants and types for the memory region attribute and ordering unit.
package mra_pkg;

  // Region start addresses; each region runs up to the next base.
  localparam logic [31:0] CODE_BASE   = 32'h00000000;
  localparam logic [31:0] SRAM_BASE   = 32'h20000000;
  localparam logic [31:0] PERIPH_BASE = 32'h40000000;
  localparam logic [31:0] XRAM_BASE   = 32'h60000000;
  localparam logic [31:0] XDEV_BASE   = 32'hA0000000;
  localparam logic [31:0] PRIV_BUS_BASE = 32'hE0000000;
  localparam logic [31:0] PRIV_BUS_LAST = 32'hE00FFFFF;
  localparam logic [31:0] VENDOR_BASE = 32'hE0100000;

  // Ordering class index into the outstanding counters.
  localparam logic [1:0] CLS_NORMAL = 2'h0;
  localparam logic [1:0] CLS_DEV_NS = 2'h1;
  localparam logic [1:0] CLS_DEV_SH = 2'h2;
  localparam logic [1:0] CLS_STRONG = 2'h3;

  typedef enum logic [1:0] {
    MT_NORMAL,
    MT_DEVICE,
    MT_STRONG
  } mra_mem_kind_type;

  typedef enum logic [1:0] {
    BS_IDLE,
    BS_MEM_BAR,
    BS_SYNC_BAR,
    BS_INST_BAR
  } mra_bar_state_type;

  // Attributes that travel beside every access.
  typedef struct packed {
    mra_mem_kind_type kind;
    logic             execute_never_attr;
    logic             shareable;
  } mra_attr_type;

  // A data access as the load/store unit presents it.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        write;
    logic        shareable;
  } mra_data_req_type;

  // Tag that the data bus echoes back with each completion.
  typedef struct packed {
    mra_attr_type attr;
    logic         write;
  } mra_tag_type;

endpackage

// ==== core/mra_region_decode.sv ====
// Combinational address map decoder giving memory type and execute-never.
`timescale 1ns/1ps
module mra_region_decode (
  // Access address and its requested shareability.
  input  wire logic [31:0]          addr,
  input  wire logic                 shareable,
  // Decoded attributes.
  output mra_pkg::mra_attr_type     attr
);

  // Walk the map from the top down so each test needs only a lower bound.
  always_comb
  begin
    attr.shareable = shareable;
    if (addr >= mra_pkg::VENDOR_BASE)
    begin
      attr.kind = mra_pkg::MT_DEVICE;
      attr.execute_never_attr = 1'b1;
    end
    else if (addr >= mra_pkg::PRIV_BUS_BASE)
    begin
      attr.kind = mra_pkg::MT_STRONG;
      attr.execute_never_attr = 1'b1;
    end
    else if (addr >= mra_pkg::XDEV_BASE)
    begin
      attr.kind = mra_pkg::MT_DEVICE;
      attr.execute_never_attr = 1'b1;
    end
    else if (addr >= mra_pkg::XRAM_BASE)
    begin
      attr.kind = mra_pkg::MT_NORMAL;
      attr.execute_never_attr = 1'b0;
    end
    else if (addr >= mra_pkg::PERIPH_BASE)
    begin
      attr.kind = mra_pkg::MT_DEVICE;
      attr.execute_never_attr = 1'b1;
    end
    else
    begin
      attr.kind = mra_pkg::MT_NORMAL;
      attr.execute_never_attr = 1'b0;
    end
  end

endmodule
